// >>> logic/drsel_consts.vh
// Constants for the run and speed selection block.
`ifndef DRSEL_CONSTS_VH
`define DRSEL_CONSTS_VH
`define DRSEL_FMODE_V0_FIRST 4'h2
`define DRSEL_FMODE_V1_I 4'h6
`define DRSEL_FMODE_V0_V1 4'h7
`define DRSEL_FN_FWD 5'h00
`define DRSEL_FN_REV 5'h01
`define DRSEL_FN_STEP_B0 5'h05
`define DRSEL_FN_STEP_B1 5'h06
`define DRSEL_FN_STEP_B2 5'h07
`define DRSEL_FN_HOLD 5'h17
`define DRSEL_RUN_KEYPAD 2'h0
`define DRSEL_RUN_TERM1 2'h1
`define DRSEL_RUN_TERM2 2'h2
`define DRSEL_INH_NONE 2'h0
`define DRSEL_INH_FWD 2'h1
`define DRSEL_INH_REV 2'h2
`define DRSEL_REG_MODE 6'h00
`define DRSEL_REG_TFUNC 6'h04
`define DRSEL_REG_STEP123 6'h08
`define DRSEL_REG_STEP45 6'h0C
`define DRSEL_REG_STEP67 6'h10
`define DRSEL_REG_CMDFREQ 6'h14
`define DRSEL_REG_STATUS 6'h18
`define DRSEL_REG_FREQOUT 6'h1C
`define DRSEL_TFUNC_RST 25'h0418820
`define DRSEL_MODE_RST 32'h00000010
`endif

// >>> logic/drsel_sync.v
// Three-stage pin synchroniser for a group of input bits.
`timescale 1ns/1ns
module drsel_sync #(
  parameter W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] lvl_reg;
  genvar i;
  // The stages keep sampling through reset so that the pins are settled
  // when reset lifts; otherwise every terminal would look off at first.
  always @(posedge aclk)
  begin
    s1_reg <= pin;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end
  // A bit changes only once the second and third stages agree; under
  // reset it follows the third stage.
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge aclk)
      begin
        if (!aresetn || s2_reg[i] == s3_reg[i])
          lvl_reg[i] <= s3_reg[i];
      end
    end
  endgenerate
  assign level = lvl_reg;
endmodule // drsel_sync

// >>> logic/drsel_top.v
// Run, stop, direction and frequency reference selection of a motor drive.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "drsel_consts.vh"
// Behaviour
// R1: Mode 6 combines voltage and current inputs.
// R2: Mode 7 combines keypad pot and voltage.
// R3: Analog hold works only in modes 2-7.
// R4: Terminal coded 23 is analog hold.
// R5: Codes 5-7 on terminals 3-5 form index.
// R6: Index zero uses mode reference and command.
// R7: Indexes 1-7 select the step frequencies.
// R8: Keypad mode: run key starts motor.
// R9: Keypad mode: stop key decelerates to stop.
// R10: Keypad mode: direction select sets rotation.
// R11: Codes 0 and 1 make forward/reverse inputs; the code takes code 0 on terminal 1 and code 1 on terminal 2 only.
// R12: Mode 1: forward/reverse inputs command direction.
// R13: Mode 1: both or neither means stop.
// R14: Mode 2: forward is run, reverse direction.
// R15: Direction inhibit blocks forward or reverse.
// R16: Autostart at power-up if terminal on.
// R17: Autostart ignored in keypad mode.
// R18: Fault reset restarts if terminal on.
// R19: Fault restart ignored in keypad mode.
// R20: Combined modes: auxiliary adds onto main.
// R21: No autostart: wait for terminal off, on.
module drsel_top #(
  parameter FW = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] input_terminals,
  input wire run_key,
  input wire stop_reset_key,
  input wire fault_cleared,
  input wire [FW-1:0] keypad_pot_input,
  input wire [FW-1:0] voltage_analog_input,
  input wire [FW-1:0] current_analog_input,
  output reg run_out,
  output reg reverse_out,
  output reg [FW-1:0] freq_ref_out
);
  wire [7:0] pins_sync;
  reg [31:0] mode_reg;
  reg cfg_done_reg;
  reg [24:0] tfunc_reg;
  reg [31:0] step123_reg;
  reg [31:0] step45_reg;
  reg [31:0] step67_reg;
  reg [FW-1:0] cmdfreq_reg;
  reg [FW-1:0] hold_val_reg;
  reg armed_reg;
  reg started_reg;
  reg key_run_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [3:0] fmode;
  reg [1:0] run_src;
  reg [1:0] inhibit;
  reg dir_sel;
  reg pwr_auto;
  reg fault_auto;
  reg fwd_in;
  reg rev_in;
  reg hold_in;
  reg [2:0] step_idx;
  reg [FW:0] sum;
  reg [FW-1:0] analog_ref;
  reg [FW-1:0] base_ref;
  reg [FW-1:0] step_ref;
  reg term_on;
  reg term_run;
  reg term_rev;
  reg want_run;
  reg want_rev;
  reg [31:0] rd_data;
  reg rd_ok;
  integer k;
  wire wr_go;
  drsel_sync #(
    .W(8)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({fault_cleared, stop_reset_key, run_key, input_terminals}),
    .level(pins_sync)
  );
  // Mode register: [3:0] freq mode, [5:4] run source, [7:6] inhibit,
  // [8] direction, [9] power-up autostart, [10] fault restart.
  always @*
  begin
    fmode = mode_reg[3:0];
    run_src = mode_reg[5:4];
    inhibit = mode_reg[7:6];
    dir_sel = mode_reg[8];
    pwr_auto = mode_reg[9];
    fault_auto = mode_reg[10];
  end
  // Terminal decode; each terminal function is five bits wide.
  always @*
  begin
    fwd_in = 1'b0;
    rev_in = 1'b0;
    hold_in = 1'b0;
    step_idx = 3'h0;
    for (k = 0; k < 5; k = k + 1)
    begin
      if (tfunc_reg[k*5 +: 5] == `DRSEL_FN_FWD && k == 0)
        fwd_in = pins_sync[k]; // see R11
      if (tfunc_reg[k*5 +: 5] == `DRSEL_FN_REV && k == 1)
        rev_in = pins_sync[k]; // see R11
      if (tfunc_reg[k*5 +: 5] == `DRSEL_FN_HOLD && pins_sync[k])
        hold_in = 1'b1; // see R4
      if (k == 2 && tfunc_reg[k*5 +: 5] == `DRSEL_FN_STEP_B0)
        step_idx[0] = pins_sync[k]; // see R5
      if (k == 3 && tfunc_reg[k*5 +: 5] == `DRSEL_FN_STEP_B1)
        step_idx[1] = pins_sync[k]; // see R5
      if (k == 4 && tfunc_reg[k*5 +: 5] == `DRSEL_FN_STEP_B2)
        step_idx[2] = pins_sync[k]; // see R5
    end
  end
  // Frequency reference selection.
  always @*
  begin
    sum = {(FW+1){1'b0}};
    case (fmode)
      4'h0, 4'h1: analog_ref = cmdfreq_reg;
      4'h2: analog_ref = keypad_pot_input;
      4'h3: analog_ref = voltage_analog_input;
      4'h4: analog_ref = current_analog_input;
      4'h5:
      begin
        sum = {1'b0, keypad_pot_input} + {1'b0, current_analog_input};
        analog_ref = sum[FW] ? {FW{1'b1}} : sum[FW-1:0]; // see R20
      end
      `DRSEL_FMODE_V1_I:
      begin
        sum = {1'b0, voltage_analog_input} + {1'b0, current_analog_input};
        analog_ref = sum[FW] ? {FW{1'b1}} : sum[FW-1:0]; // see R1 R20
      end
      `DRSEL_FMODE_V0_V1:
      begin
        sum = {1'b0, keypad_pot_input} + {1'b0, voltage_analog_input};
        analog_ref = sum[FW] ? {FW{1'b1}} : sum[FW-1:0]; // see R2 R20
      end
      default: analog_ref = cmdfreq_reg;
    endcase
    // Hold freezes the analog reference only in analog modes.
    if (hold_in && fmode >= `DRSEL_FMODE_V0_FIRST &&
        fmode <= `DRSEL_FMODE_V0_V1)
      base_ref = hold_val_reg; // see R3 R4
    else
      base_ref = analog_ref;
    case (step_idx)
      3'h0: step_ref = base_ref; // see R6
      3'h1: step_ref = step123_reg[FW-1:0]; // see R7
      3'h2: step_ref = step123_reg[31:16];
      3'h3: step_ref = step45_reg[31:16];
      3'h4: step_ref = step67_reg[FW-1:0]; // see R7
      3'h5: step_ref = step67_reg[31:16];
      3'h6: step_ref = mode_reg[31:16];
      default: step_ref = step45_reg[FW-1:0];
    endcase
  end
  // Run and direction from the selected source.
  always @*
  begin
    term_on = 1'b0;
    term_run = 1'b0;
    term_rev = 1'b0;
    if (run_src == `DRSEL_RUN_TERM1)
    begin
      term_run = fwd_in ^ rev_in; // see R12 R13
      term_rev = rev_in; // see R12
      term_on = fwd_in | rev_in;
    end
    else if (run_src == `DRSEL_RUN_TERM2)
    begin
      term_run = fwd_in; // see R14
      term_rev = rev_in; // see R14
      term_on = fwd_in;
    end
    if (run_src == `DRSEL_RUN_KEYPAD)
    begin
      want_run = key_run_reg; // see R8 R9
      want_rev = dir_sel; // see R10
    end
    else
    begin
      want_run = term_run && started_reg;
      want_rev = term_rev;
    end
    if ((inhibit == `DRSEL_INH_FWD && !want_rev) ||
        (inhibit == `DRSEL_INH_REV && want_rev))
      want_run = 1'b0; // see R15
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_run_reg <= 1'b0;
      armed_reg <= 1'b1;
      started_reg <= 1'b0;
      hold_val_reg <= {FW{1'b0}};
      run_out <= 1'b0;
      reverse_out <= 1'b0;
      freq_ref_out <= {FW{1'b0}};
    end
    else
    begin
      if (pins_sync[6])
        key_run_reg <= 1'b0; // see R9
      else if (pins_sync[5] && run_src == `DRSEL_RUN_KEYPAD)
        key_run_reg <= 1'b1; // see R8
      if (!hold_in)
        hold_val_reg <= analog_ref;
      // Power counts as applied until the mode word has been loaded, since
      // the mode word is volatile and reset loads it with DRSEL_MODE_RST.
      if (cfg_done_reg)
        armed_reg <= 1'b0;
      if (run_src == `DRSEL_RUN_KEYPAD || !term_on)
        started_reg <= !term_on && run_src != `DRSEL_RUN_KEYPAD; // see R21
      else if (armed_reg && pwr_auto)
        started_reg <= 1'b1; // see R16 R17
      else if (pins_sync[7] && fault_auto)
        started_reg <= 1'b1; // see R18 R19
      run_out <= want_run;
      reverse_out <= want_rev;
      freq_ref_out <= step_ref;
    end
  end
  // AXI4-Lite write channel: address and data taken in either order.
  assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      cfg_done_reg <= 1'b0;
      mode_reg <= `DRSEL_MODE_RST;
      tfunc_reg <= `DRSEL_TFUNC_RST;
      step123_reg <= 32'h00000000;
      step45_reg <= 32'h00000000;
      step67_reg <= 32'h00000000;
      cmdfreq_reg <= {FW{1'b0}};
    end
    else
    begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // Only whole-word writes land; a partial strobe is refused.
        if (awaddr_reg[31:6] != 26'h0000000 || wstrb_reg != 4'hF)
          s_axi_bresp <= 2'h2;
        else
          case (awaddr_reg[5:0])
            `DRSEL_REG_MODE:
            begin
              mode_reg <= wdata_reg;
              cfg_done_reg <= 1'b1;
            end
            `DRSEL_REG_TFUNC: tfunc_reg <= wdata_reg[24:0];
            `DRSEL_REG_STEP123: step123_reg <= wdata_reg;
            `DRSEL_REG_STEP45: step45_reg <= wdata_reg;
            `DRSEL_REG_STEP67: step67_reg <= wdata_reg;
            `DRSEL_REG_CMDFREQ: cmdfreq_reg <= wdata_reg[FW-1:0];
            default: s_axi_bresp <= 2'h2;
          endcase
      end
    end
  end
  // Read decode.
  always @*
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr[5:0])
      `DRSEL_REG_MODE: rd_data = mode_reg;
      `DRSEL_REG_TFUNC: rd_data = {7'h00, tfunc_reg};
      `DRSEL_REG_STEP123: rd_data = step123_reg;
      `DRSEL_REG_STEP45: rd_data = step45_reg;
      `DRSEL_REG_STEP67: rd_data = step67_reg;
      `DRSEL_REG_CMDFREQ: rd_data = {{(32-FW){1'b0}}, cmdfreq_reg};
      `DRSEL_REG_STATUS: rd_data = {21'h000000, step_idx, hold_in,
        pins_sync[4:0], reverse_out, run_out};
      `DRSEL_REG_FREQOUT: rd_data = {{(32-FW){1'b0}}, freq_ref_out};
      default:
      begin
        rd_data = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    if (s_axi_araddr[31:6] != 26'h0000000)
      rd_ok = 1'b0;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // drsel_top

// >>> test/drsel_contacts.sv
// Keypad keys and contact terminals facing the selection block.
`timescale 1ns/1ns
module drsel_contacts (
  input wire logic aclk,
  input wire logic [4:0] term_set,
  input wire logic [2:0] key_set,
  output logic [4:0] input_terminals = 5'h00,
  output logic [2:0] keys = 3'h0
);
  // Contacts move just after an edge; the block synchronises them itself.
  always @(posedge aclk)
  begin
    input_terminals <= term_set;
    keys <= key_set;
  end
endmodule // drsel_contacts

// >>> test/drsel_chk.sv
// Port checks of the register bus and of the run output.
`timescale 1ns/1ns
module drsel_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire run_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_resp_legal: assert property (s_axi_bvalid
    |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("extra read answer");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("extra write answer");
  a_wready_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held");
  a_first_stop: assert property ($rose(aresetn) |-> !run_out[*3])
    else $error("run after reset");
endmodule // drsel_chk
bind drsel_top drsel_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .run_out(run_out));

// >>> test/drive_run_and_speed_select_test.sv
// Self-checking bench for the run and speed selection block.
`timescale 1ns/1ns
`include "drsel_consts.vh"
module drive_run_and_speed_select_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, run_out, reverse_out;
  logic [31:0] awaddr, wdata, araddr, rdata, seed;
  logic [1:0] bresp, rresp;
  logic [4:0] tset, term;
  logic [2:0] kset, keys;
  logic [15:0] pot, volt, curr, freq, e;
  logic [15:0] s [0:7];
  logic [1:0] wq [$];
  logic [33:0] rq [$], mq [$];
  int fails, checks_done, i;
  drsel_contacts far_u (.aclk(aclk), .term_set(tset), .key_set(kset),
    .input_terminals(term), .keys(keys));
  drsel_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .input_terminals(term),
    .run_key(keys[0]), .stop_reset_key(keys[1]), .fault_cleared(keys[2]),
    .keypad_pot_input(pot), .voltage_analog_input(volt),
    .current_analog_input(curr), .run_out(run_out),
    .reverse_out(reverse_out), .freq_ref_out(freq));
  always #2 aclk = ~aclk;
  task chk(input string n, input [33:0] v, input [33:0] x);
    begin
      checks_done++;
      if (v !== x)
      begin
        fails++;
        $display("unexpected %s: expected %h, seen %h", n, x, v);
      end
    end
  endtask
  always @(posedge aclk)
  begin
    if (bvalid && bready)
      chk("bresp", {32'h0, bresp}, {32'h0, wq.pop_front()});
    if (rvalid && rready)
      chk("rdata", {rresp, rdata} & mq.pop_front(), rq.pop_front());
  end
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
      @(posedge aclk);
      wq.push_back(r);
      awaddr <= {24'h0, a};
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] x, input [31:0] m, input [1:0] r);
    begin
      @(posedge aclk);
      rq.push_back({r, x & m});
      mq.push_back({2'h3, m});
      araddr <= {24'h0, a};
      {arvalid, rready} <= 2'h3;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'b0;
    end
  endtask
  // A contact change needs about six cycles to reach the outputs.
  task pins(input [4:0] v);
    begin
      tset <= v;
      repeat (8) @(posedge aclk);
    end
  endtask
  task key(input [2:0] k);
    begin
      kset <= k;
      repeat (8) @(posedge aclk);
      kset <= 3'h0;
      repeat (8) @(posedge aclk);
    end
  endtask
  task st(input [1:0] x, input [1:0] m);
    rd(`DRSEL_REG_STATUS, {30'h0, x}, {30'h0, m}, 2'h0);
  endtask
  task ps(input [4:0] v, input [1:0] x, input [1:0] m);
    begin
      pins(v);
      st(x, m);
    end
  endtask
  task fr(input [15:0] x);
    rd(`DRSEL_REG_FREQOUT, {16'h0, x}, 32'h0000FFFF, 2'h0);
  endtask
  function automatic [15:0] sat(input [15:0] a, input [15:0] b);
    sat = ({1'b0, a} + b > 17'h0FFFF) ? 16'hFFFF : a + b;
  endfunction
  task results;
    begin
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    #200000;
    fails++;
    results();
  end
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {kset, awaddr, wdata, araddr, pot, volt, curr} = 147'h0;
    tset = 5'h01;
    fails = 0;
    checks_done = 0;
    seed = $urandom(32'hEA321798);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DRSEL_REG_MODE, `DRSEL_MODE_RST, 32'hFFFFFFFF, 2'h0);
    rd(`DRSEL_REG_TFUNC, {7'h0, `DRSEL_TFUNC_RST}, 32'hFFFFFFFF, 2'h0);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(`DRSEL_REG_STATUS, 32'h1, 2'h2);
    st(2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000410, 2'h0);
    key(3'h4);
    st(2'h1, 2'h3);
    ps(5'h00, 2'h0, 2'h1);
    ps(5'h01, 2'h1, 2'h3);
    ps(5'h02, 2'h3, 2'h3);
    ps(5'h03, 2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000050, 2'h0);
    ps(5'h01, 2'h0, 2'h1);
    ps(5'h02, 2'h3, 2'h3);
    wr(`DRSEL_REG_MODE, 32'h00000090, 2'h0);
    ps(5'h01, 2'h1, 2'h3);
    ps(5'h02, 2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000020, 2'h0);
    ps(5'h01, 2'h1, 2'h3);
    ps(5'h03, 2'h3, 2'h3);
    ps(5'h02, 2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000400, 2'h0);
    ps(5'h01, 2'h0, 2'h1);
    key(3'h4);
    st(2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000100, 2'h0);
    key(3'h1);
    st(2'h3, 2'h3);
    key(3'h3);
    st(2'h0, 2'h1);
    wr(`DRSEL_REG_MODE, 32'h00000000, 2'h0);
    key(3'h1);
    st(2'h1, 2'h3);
    key(3'h2);
    st(2'h0, 2'h1);
    for (i = 0; i < 8; i++)
      s[i] = $urandom;
    wr(`DRSEL_REG_TFUNC, 32'h00731420, 2'h0);
    wr(`DRSEL_REG_STEP123, {s[2], s[1]}, 2'h0);
    wr(`DRSEL_REG_STEP45, {s[3], s[7]}, 2'h0);
    wr(`DRSEL_REG_STEP67, {s[5], s[4]}, 2'h0);
    wr(`DRSEL_REG_CMDFREQ, {16'h0, s[0]}, 2'h0);
    wr(`DRSEL_REG_MODE, {s[6], 16'h0}, 2'h0);
    for (i = 0; i < 8; i++)
    begin
      pins({i[2:0], 2'h0});
      fr(s[i]);
    end
    pins(5'h00);
    for (i = 6; i < 8; i++)
    begin
      pot <= $urandom;
      volt <= $urandom;
      curr <= $urandom;
      wr(`DRSEL_REG_MODE, i, 2'h0);
      e = (i == 6) ? sat(volt, curr) : sat(pot, volt);
      fr(e);
    end
    wr(`DRSEL_REG_TFUNC, 32'h01700020, 2'h0);
    wr(`DRSEL_REG_MODE, 32'h00000006, 2'h0);
    pins(5'h10);
    e = sat(volt, curr);
    volt <= $urandom;
    curr <= $urandom;
    fr(e);
    pins(5'h00);
    fr(sat(volt, curr));
    wr(`DRSEL_REG_MODE, 32'h00000000, 2'h0);
    pins(5'h10);
    fr(s[0]);
    tset <= 5'h01;
    for (i = 0; i < 2; i++)
    begin
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      st(2'h0, 2'h1);
      wr(`DRSEL_REG_MODE, 32'h00000200 | (i << 4), 2'h0);
      st(i[1:0], 2'h1);
    end
    results();
  end
endmodule // drive_run_and_speed_select_test
